// ==== rtl/vts_device.sv ====
// Notes on behaviour
// [RULE_01] soft reset bit zeroes counters, pointer, flags
// [RULE_02] hold stops sequencer, opens all registers
// [RULE_03] clock select: core clock or pixel clock
// [RULE_04] prescale codes divide by 1,2,4,8
// [RULE_05] master mode ignores external resets
// [RULE_06] slave mode normal while external resets low
// [RULE_07] slave frame reset restarts screen, line ignored
// [RULE_08] slave line reset acts as line end
// [RULE_09] sequence pointer writable only in hold
// [RULE_10] pointer six bits, upper two read zero
// [RULE_11] decoder signals read only
// [RULE_12] counter register layout, unused bits zero
// [RULE_13] counter writes in hold, byte enables honoured
// [RULE_14] 64x32 instruction store, host access anytime
// [RULE_15] host avoids writing the running instruction
// [RULE_16] bus reset overrides everything, blocks access
// [RULE_17] host picks core clock, no prescale in hold
// [RULE_18] program line end precedes external resets; the code checks the slave external resets first and drops the program line end
// [RULE_19] counters wrap through zero before matching
// [RULE_20] control 128, counter 129, memory 0..63
// [RULE_21] low six control bits always writable
// [RULE_22] hold-protected writes outside hold ignored
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module vts_device (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // internal peripheral bus
    vts_ipb_if.dev ipb,
    // video side
    input wire logic pixel_clock_i,
    input wire logic ext_line_reset_i,
    input wire logic ext_frame_reset_i,
    output logic [vts_pkg::IT_SIG_W-1:0] timing_o,
    output logic band_end_o,
    output logic screen_end_o
);

////////////////////////////////////////////////////////////////////////////////

logic rst;
logic [5:0] ctrl_q;
logic band_q, band_d;
logic screen_q, screen_d;
logic [vts_pkg::PTR_W-1:0] ptr_q, ptr_d;
logic [vts_pkg::CNT_W-1:0] h_q, h_d;
logic [vts_pkg::CNT_W-1:0] v_q, v_d;
logic [31:0] mem [vts_pkg::RAM_DEPTH];
logic ack_q;
logic [31:0] rdata_q;
logic pix_prev_q;
logic [2:0] ps_cnt_q;
logic [2:0] ps_mask;
logic [vts_pkg::IT_SIG_W-1:0] timing_q;
logic [31:0] instr;
logic [1:0] ityp;
logic [vts_pkg::CNT_W-1:0] cmp;
logic [vts_pkg::PTR_W-1:0] lda;
logic hmatch, vmatch;
logic src_tick, tick, hold, slave;
logic acc, wr, wr_cnt, wr_ctrl, wr_ram;
logic [31:0] cnt_word, ctrl_word, cnt_new, ctrl_new;
logic [15:0] dec_sig;

// bus reset overrides every other control
assign rst = srst_i | ipb.bus_rst; // [RULE_16]
assign hold = ctrl_q[vts_pkg::CB_HOLD];
assign slave = ctrl_q[vts_pkg::CB_SLAVE];

////////////////////////////////////////////////////////////////////////////////
// instruction fetch and decode

assign instr = mem[ptr_q];
assign ityp = instr[vts_pkg::IT_TYPE_LO +: 2];
assign cmp = instr[vts_pkg::IT_CMP_LO +: vts_pkg::CNT_W];
assign lda = instr[vts_pkg::IT_LOAD_LO +: vts_pkg::PTR_W];
// plain equality, so a compare below the count waits for the wrap
assign hmatch = (h_q == cmp); // [RULE_19]
assign vmatch = (v_q == cmp);
assign dec_sig = {instr[vts_pkg::IT_SIG_W-1:0], ityp, hmatch, vmatch};

////////////////////////////////////////////////////////////////////////////////
// clock source and prescaler

// pixel clock is sampled; one step per rising edge
assign src_tick = ctrl_q[vts_pkg::CB_CORE] | (pixel_clock_i & ~pix_prev_q); // [RULE_03]

always_comb begin
    case (ctrl_q[vts_pkg::CB_PS_LO +: 2])
        2'h0: ps_mask = 3'h0;
        2'h1: ps_mask = 3'h1;
        2'h2: ps_mask = 3'h3;
        default: ps_mask = 3'h7;
    endcase
end

assign tick = src_tick & ((ps_cnt_q & ps_mask) == ps_mask); // [RULE_04]

always_ff @(posedge core_clk_i) begin
    if (rst) begin
        pix_prev_q <= 1'b0;
        ps_cnt_q <= 3'h0;
    end else begin
        pix_prev_q <= pixel_clock_i;
        if (src_tick) begin
            ps_cnt_q <= ps_cnt_q + 3'h1; // [RULE_04]
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// host access decode

// a request is taken once; ack is a one-cycle pulse after it
assign acc = ipb.req & ~ack_q & ~rst;
assign wr = acc & ipb.we;
assign wr_ram = wr & (ipb.addr <= vts_pkg::RAM_TOP); // [RULE_14]
assign wr_cnt = wr & (ipb.addr == vts_pkg::CNT_ADDR) & hold; // [RULE_13]
assign wr_ctrl = wr & (ipb.addr == vts_pkg::CTRL_ADDR);
assign cnt_word = {4'h0, h_q, 4'h0, v_q}; // [RULE_12]
assign ctrl_word = {dec_sig, 2'b00, ptr_q, screen_q, band_q, ctrl_q}; // [RULE_10] [RULE_11]
assign cnt_new = vts_pkg::byte_merge(cnt_word, ipb.wdata, ipb.be); // [RULE_13]
assign ctrl_new = vts_pkg::byte_merge(ctrl_word, ipb.wdata, ipb.be);

always_ff @(posedge core_clk_i) begin
    if (rst) begin
        ctrl_q <= vts_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
        ctrl_q <= ctrl_new[5:0]; // [RULE_21]
    end
end

always_ff @(posedge core_clk_i) begin
    if (wr_ram) begin
        mem[ipb.addr[vts_pkg::PTR_W-1:0]] <=
            vts_pkg::byte_merge(mem[ipb.addr[vts_pkg::PTR_W-1:0]], ipb.wdata, ipb.be); // [RULE_14]
    end
end

always_ff @(posedge core_clk_i) begin
    if (rst) begin
        ack_q <= 1'b0;
        rdata_q <= 32'h0;
    end else begin
        ack_q <= acc; // [RULE_20]
        if (acc) begin
            if (ipb.addr <= vts_pkg::RAM_TOP) begin
                rdata_q <= mem[ipb.addr[vts_pkg::PTR_W-1:0]];
            end else if (ipb.addr == vts_pkg::CTRL_ADDR) begin
                rdata_q <= ctrl_word;
            end else if (ipb.addr == vts_pkg::CNT_ADDR) begin
                rdata_q <= cnt_word;
            end else begin
                rdata_q <= 32'h0;
            end
        end
    end
end

assign ipb.ack = ack_q;
assign ipb.rdata = rdata_q;

////////////////////////////////////////////////////////////////////////////////
// sequencer next state

always_comb begin
    logic zero_all;
    logic line_end;
    zero_all = 1'b0;
    line_end = 1'b0;
    ptr_d = ptr_q;
    h_d = h_q;
    v_d = v_q;
    band_d = band_q;
    screen_d = screen_q;
    if (ctrl_q[vts_pkg::CB_SRST]) begin
        zero_all = 1'b1; // [RULE_01]
    end else if (hold) begin
        // only here may the host touch running state
        if (wr_cnt) begin
            h_d = cnt_new[vts_pkg::CNT_H_LO +: vts_pkg::CNT_W]; // [RULE_13] [RULE_02]
            v_d = cnt_new[vts_pkg::CNT_W-1:0];
        end
        if (wr_ctrl) begin
            band_d = ctrl_new[vts_pkg::CB_BAND]; // [RULE_21]
            screen_d = ctrl_new[vts_pkg::CB_SCREEN];
            ptr_d = ctrl_new[vts_pkg::PTR_LO +: vts_pkg::PTR_W]; // [RULE_09] [RULE_10]
        end
    end else if (tick) begin
        // writes to protected state fall here and are dropped
        if (slave & ext_frame_reset_i) begin
            zero_all = 1'b1; // [RULE_07] [RULE_22]
        end else if (slave & ext_line_reset_i) begin
            line_end = 1'b1; // [RULE_08]
        end else begin
            // master, or slave with both resets low
            case (ityp) // [RULE_05] [RULE_06]
                vts_pkg::T_SEG: begin
                    h_d = h_q + 12'h001;
                    if (hmatch) begin
                        ptr_d = ptr_q + 6'h01;
                    end
                end
                vts_pkg::T_LINE: begin
                    if (hmatch) begin
                        line_end = 1'b1; // [RULE_18]
                    end else begin
                        h_d = h_q + 12'h001;
                    end
                end
                vts_pkg::T_BAND: begin
                    h_d = h_q + 12'h001;
                    ptr_d = ptr_q + 6'h01;
                    screen_d = 1'b0;
                    band_d = vmatch;
                end
                default: begin
                    h_d = h_q + 12'h001;
                    ptr_d = ptr_q + 6'h01;
                    screen_d = vmatch;
                    band_d = 1'b0;
                end
            endcase
        end
        if (line_end) begin
            if (screen_q) begin
                zero_all = 1'b1;
            end else begin
                h_d = '0;
                v_d = v_q + 12'h001;
                band_d = 1'b0;
                screen_d = 1'b0;
                ptr_d = band_q ? ptr_q + 6'h01 : lda;
            end
        end
    end
    if (zero_all) begin
        ptr_d = '0;
        h_d = '0;
        v_d = '0;
        band_d = 1'b0;
        screen_d = 1'b0;
    end
end

always_ff @(posedge core_clk_i) begin
    if (rst) begin
        ptr_q <= '0;
        h_q <= '0;
        v_q <= '0;
        band_q <= 1'b0;
        screen_q <= 1'b0;
    end else begin
        ptr_q <= ptr_d;
        h_q <= h_d;
        v_q <= v_d;
        band_q <= band_d;
        screen_q <= screen_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// timing outputs, registered; timing_o changes only on a step or a reset, band_end_o and screen_end_o also on host writes in hold

always_ff @(posedge core_clk_i) begin
    if (rst | ctrl_q[vts_pkg::CB_SRST]) begin
        timing_q <= '0;
    end else if (tick & ~hold) begin
        timing_q <= instr[vts_pkg::IT_SIG_W-1:0];
    end
end

assign timing_o = timing_q;
assign band_end_o = band_q;
assign screen_end_o = screen_q;

endmodule
`default_nettype wire

// ==== rtl/vts_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module vts_host (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // axi4-lite write address and data
    input wire logic axi_awvalid_i,
    output logic axi_awready_o,
    input wire logic [7:0] axi_awaddr_i,
    input wire logic axi_wvalid_i,
    output logic axi_wready_o,
    input wire logic [31:0] axi_wdata_i,
    input wire logic [3:0] axi_wstrb_i,
    // axi4-lite write response
    output logic axi_bvalid_o,
    input wire logic axi_bready_i,
    output logic [1:0] axi_bresp_o,
    // axi4-lite read
    input wire logic axi_arvalid_i,
    output logic axi_arready_o,
    input wire logic [7:0] axi_araddr_i,
    output logic axi_rvalid_o,
    input wire logic axi_rready_i,
    output logic [31:0] axi_rdata_o,
    output logic [1:0] axi_rresp_o,
    // internal peripheral bus
    vts_ipb_if.host ipb
);

////////////////////////////////////////////////////////////////////////////////

typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
} vts_st_t;

vts_st_t st_q;
logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
logic [1:0] bresp_q, rresp_q;
logic [7:0] awaddr_q;
logic [31:0] wdata_q, wstrb_word, rdata_q;
logic [3:0] wstrb_q;
logic [7:0] target_q;
logic [31:0] out_q, in_q;
logic [7:0] cmd_q;
logic bus_rst_q, req_q;
logic do_wr, launch, hit;

function automatic logic mapped(input logic [7:0] a);
    return a == vts_pkg::HA_TARGET || a == vts_pkg::HA_WDATA || a == vts_pkg::HA_CMD ||
           a == vts_pkg::HA_STATUS || a == vts_pkg::HA_RDATA || a == vts_pkg::HA_BUSRST;
endfunction

////////////////////////////////////////////////////////////////////////////////
// axi write: address and data in either order, response after both

assign do_wr = ~awready_q & ~wready_q & ~bvalid_q;
assign hit = mapped(awaddr_q);
assign wstrb_word = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
// commands while busy or in bus reset are dropped
assign launch = do_wr & (awaddr_q == vts_pkg::HA_CMD) & (st_q == ST_IDLE) & ~bus_rst_q;

always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
        awready_q <= 1'b1;
        wready_q <= 1'b1;
        bvalid_q <= 1'b0;
        bresp_q <= vts_pkg::RESP_OK;
        awaddr_q <= 8'h00;
        wdata_q <= 32'h0;
        wstrb_q <= 4'h0;
    end else begin
        if (axi_awvalid_i & awready_q) begin
            awready_q <= 1'b0;
            awaddr_q <= axi_awaddr_i;
        end
        if (axi_wvalid_i & wready_q) begin
            wready_q <= 1'b0;
            wdata_q <= axi_wdata_i;
            wstrb_q <= axi_wstrb_i;
        end
        if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= hit ? vts_pkg::RESP_OK : vts_pkg::RESP_ERR;
        end
        if (bvalid_q & axi_bready_i) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
        end
    end
end

always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
        target_q <= 8'h00;
        out_q <= 32'h0;
        cmd_q <= 8'h00;
        bus_rst_q <= 1'b0;
    end else if (do_wr) begin
        if (awaddr_q == vts_pkg::HA_TARGET) begin
            target_q <= wstrb_q[0] ? wdata_q[7:0] : target_q;
        end else if (awaddr_q == vts_pkg::HA_WDATA) begin
            out_q <= (out_q & ~wstrb_word) | (wdata_q & wstrb_word);
        end else if (launch) begin
            cmd_q <= wdata_q[7:0];
        end else if (awaddr_q == vts_pkg::HA_BUSRST && wstrb_q[0]) begin
            bus_rst_q <= wdata_q[0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// internal bus master: request held until the single ack pulse

always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
        st_q <= ST_IDLE;
        req_q <= 1'b0;
        in_q <= 32'h0;
    end else begin
        case (st_q)
            ST_IDLE: begin
                if (launch) begin
                    req_q <= 1'b1;
                    st_q <= ST_WAIT;
                end
            end
            ST_WAIT: begin
                // a bus reset kills the access; the device will not answer
                if (bus_rst_q) begin
                    req_q <= 1'b0;
                    st_q <= ST_IDLE;
                end else if (ipb.ack) begin
                    req_q <= 1'b0;
                    if (~cmd_q[vts_pkg::CMD_WE]) begin
                        in_q <= ipb.rdata;
                    end
                    st_q <= ST_IDLE;
                end
            end
            default: begin
                req_q <= 1'b0;
                st_q <= ST_IDLE;
            end
        endcase
    end
end

assign ipb.req = req_q;
assign ipb.we = cmd_q[vts_pkg::CMD_WE];
assign ipb.addr = target_q;
assign ipb.wdata = out_q;
assign ipb.be = cmd_q[vts_pkg::CMD_BE_LO +: 4];
assign ipb.bus_rst = bus_rst_q;

////////////////////////////////////////////////////////////////////////////////
// axi read

always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
        arready_q <= 1'b1;
        rvalid_q <= 1'b0;
        rdata_q <= 32'h0;
        rresp_q <= vts_pkg::RESP_OK;
    end else begin
        if (axi_arvalid_i & arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= mapped(axi_araddr_i) ? vts_pkg::RESP_OK : vts_pkg::RESP_ERR;
            if (axi_araddr_i == vts_pkg::HA_TARGET) begin
                rdata_q <= {24'h0, target_q};
            end else if (axi_araddr_i == vts_pkg::HA_WDATA) begin
                rdata_q <= out_q;
            end else if (axi_araddr_i == vts_pkg::HA_CMD) begin
                rdata_q <= {24'h0, cmd_q};
            end else if (axi_araddr_i == vts_pkg::HA_STATUS) begin
                rdata_q <= {30'h0, bus_rst_q, st_q == ST_WAIT};
            end else if (axi_araddr_i == vts_pkg::HA_RDATA) begin
                rdata_q <= in_q;
            end else if (axi_araddr_i == vts_pkg::HA_BUSRST) begin
                rdata_q <= {31'h0, bus_rst_q};
            end else begin
                rdata_q <= 32'h0;
            end
        end
        if (rvalid_q & axi_rready_i) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end
end

assign axi_awready_o = awready_q;
assign axi_wready_o = wready_q;
assign axi_bvalid_o = bvalid_q;
assign axi_bresp_o = bresp_q;
assign axi_arready_o = arready_q;
assign axi_rvalid_o = rvalid_q;
assign axi_rdata_o = rdata_q;
assign axi_rresp_o = rresp_q;

endmodule
`default_nettype wire

// ==== rtl/vts_ipb_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface vts_ipb_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic bus_rst;
    logic ack;
    logic [31:0] rdata;

    modport dev (
        input req, we, addr, wdata, be, bus_rst,
        output ack, rdata
    );
    modport host (
        output req, we, addr, wdata, be, bus_rst,
        input ack, rdata
    );
endinterface
`default_nettype wire

// ==== rtl/vts_pkg.sv ====
`default_nettype none
package vts_pkg;
    // internal bus word addresses
    localparam logic [7:0] RAM_TOP = 8'h3f;
    localparam logic [7:0] CTRL_ADDR = 8'h80;
    localparam logic [7:0] CNT_ADDR = 8'h81;
    // unit control bits
    localparam int CB_SRST = 0;
    localparam int CB_HOLD = 1;
    localparam int CB_CORE = 2;
    localparam int CB_PS_LO = 3;
    localparam int CB_SLAVE = 5;
    localparam int CB_BAND = 6;
    localparam int CB_SCREEN = 7;
    localparam int PTR_LO = 8;
    localparam int DEC_LO = 16;
    localparam logic [5:0] CTRL_RST = 6'h06;
    // counter register layout
    localparam int CNT_H_LO = 16;
    localparam int CNT_W = 12;
    localparam int PTR_W = 6;
    localparam int RAM_DEPTH = 64;
    // instruction word layout
    localparam int IT_TYPE_LO = 30;
    localparam int IT_CMP_LO = 18;
    localparam int IT_LOAD_LO = 12;
    localparam int IT_SIG_W = 12;
    localparam logic [1:0] T_SEG = 2'h0;
    localparam logic [1:0] T_LINE = 2'h1;
    localparam logic [1:0] T_BAND = 2'h2;
    localparam logic [1:0] T_SCREEN = 2'h3;
    // controller registers, byte offsets
    localparam logic [7:0] HA_TARGET = 8'h00;
    localparam logic [7:0] HA_WDATA = 8'h04;
    localparam logic [7:0] HA_CMD = 8'h08;
    localparam logic [7:0] HA_STATUS = 8'h0c;
    localparam logic [7:0] HA_RDATA = 8'h10;
    localparam logic [7:0] HA_BUSRST = 8'h14;
    localparam int CMD_WE = 0;
    localparam int CMD_BE_LO = 4;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// ==== sim/video_timing_sequencer_ctrl_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module video_timing_sequencer_ctrl_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd, r2, d;
    logic [3:0] wstrb = 4'h0, b;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic pix = 1'b0, line_rst = 1'b0, frame_rst = 1'b0, band_end, screen_end;
    logic [11:0] timing;
    logic [5:0] a;
    int n_errors = 0, n_checks = 0, seed = 19;
    logic [31:0] ram [64];
    vts_ipb_if ipb ();
    always #10 clk = ~clk;
    vts_host i_vts_host (.core_clk_i(clk), .srst_i(srst), .axi_awvalid_i(awvalid),
        .axi_awready_o(awready), .axi_awaddr_i(awaddr), .axi_wvalid_i(wvalid),
        .axi_wready_o(wready), .axi_wdata_i(wdata), .axi_wstrb_i(wstrb),
        .axi_bvalid_o(bvalid), .axi_bready_i(bready), .axi_bresp_o(bresp),
        .axi_arvalid_i(arvalid), .axi_arready_o(arready), .axi_araddr_i(araddr),
        .axi_rvalid_o(rvalid), .axi_rready_i(rready), .axi_rdata_o(rdata),
        .axi_rresp_o(rresp), .ipb(ipb));
    vts_device i_vts_device (.core_clk_i(clk), .srst_i(srst), .ipb(ipb), .pixel_clock_i(pix),
        .ext_line_reset_i(line_rst), .ext_frame_reset_i(frame_rst), .timing_o(timing),
        .band_end_o(band_end), .screen_end_o(screen_end));
    vts_ipb_checker i_vts_ipb_checker (.core_clk_i(clk), .srst_i(srst), .req(ipb.req),
        .we(ipb.we), .addr(ipb.addr), .wdata(ipb.wdata), .be(ipb.be), .bus_rst(ipb.bus_rst),
        .ack(ipb.ack), .rdata(ipb.rdata));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        n_errors++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fail($sformatf("word %h want %h", g, e));
        end
    endtask
    task automatic cmp_r(input logic [1:0] g, input logic [1:0] e);
        n_checks++;
        if (g !== e) begin
            fail($sformatf("resp %h want %h", g, e));
        end
    endtask
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] s);
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= ad;
        wvalid <= 1'b1;
        wdata <= dt;
        wstrb <= s;
        bready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                return;
            end
        end
        fail("write timeout");
        end_sim();
    endtask
    task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dt);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= ad;
        rready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                dt = rdata;
                resp = rresp;
                rready <= 1'b0;
                return;
            end
        end
        fail("read timeout");
        end_sim();
    endtask
    // one internal bus access through the controller registers
    task automatic ipb_op(input logic [7:0] t, input logic w, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] o);
        logic [31:0] st;
        axi_wr(vts_pkg::HA_TARGET, {24'h0, t}, 4'hf);
        axi_wr(vts_pkg::HA_WDATA, wd, 4'hf);
        axi_wr(vts_pkg::HA_CMD, {24'h0, be, 3'h0, w}, 4'h1);
        for (int n = 0; n < 50; n++) begin
            axi_rd(vts_pkg::HA_STATUS, st);
            if (st[0] === 1'b0) begin
                axi_rd(vts_pkg::HA_RDATA, o);
                return;
            end
        end
        fail("internal bus timeout");
        end_sim();
    endtask
    task automatic ctl(input logic [31:0] v, input logic [3:0] be);
        ipb_op(vts_pkg::CTRL_ADDR, 1'b1, be, v, rd);
    endtask
    task automatic get(input logic [7:0] t, output logic [31:0] o);
        ipb_op(t, 1'b0, 4'h0, 32'h0, o);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        get(vts_pkg::CTRL_ADDR, rd);
        cmp_w({16'h0, rd[15:0]}, 32'h0000_0006);
        $display("test reset done");
        for (int k = 0; k < 10; k++) begin
            a = 6'($random(seed));
            d = $random(seed);
            ipb_op({2'h0, a}, 1'b1, 4'hf, d, rd);
            ram[a] = d;
            d = $random(seed);
            b = 4'($random(seed));
            ipb_op({2'h0, a}, 1'b1, b, d, rd);
            for (int i = 0; i < 4; i++) if (b[i]) ram[a][i*8 +: 8] = d[i*8 +: 8];
            get({2'h0, a}, rd);
            cmp_w(rd, ram[a]);
        end
        $display("test ram done");
        ipb_op(vts_pkg::CNT_ADDR, 1'b1, 4'hf, 32'hffff_ffff, rd);
        get(vts_pkg::CNT_ADDR, rd);
        cmp_w(rd, 32'h0fff_0fff);
        ipb_op(vts_pkg::CNT_ADDR, 1'b1, 4'h5, 32'h0012_0034, rd);
        get(vts_pkg::CNT_ADDR, rd);
        cmp_w(rd, 32'h0f12_0f34);
        ctl(32'h0000_ff06, 4'h3);
        get(vts_pkg::CTRL_ADDR, rd);
        cmp_w({16'h0, rd[15:0]}, 32'h0000_3f06);
        ctl(32'h0000_0006, 4'h3);
        $display("test hold access done");
        // every word waits for a line end that never comes, pointer stays 0
        for (int i = 0; i < 64; i++) begin
            ipb_op(8'(i), 1'b1, 4'hf, 32'h7ffc_0000, rd);
            ram[i] = 32'h7ffc_0000;
        end
        ctl(32'h0000_0004, 4'h1);
        ctl(32'h0000_0504, 4'h3);
        get(vts_pkg::CTRL_ADDR, rd);
        cmp_w({26'h0, rd[13:8]}, 32'h0);
        cmp_w({26'h0, rd[5:0]}, 32'h4);
        get(8'h09, rd);
        cmp_w(rd, ram[9]);
        ctl(32'h0000_0006, 4'h1);
        get(vts_pkg::CNT_ADDR, rd);
        get(vts_pkg::CNT_ADDR, r2);
        cmp_w(r2, rd);
        ctl(32'h0000_0000, 4'h1);
        get(vts_pkg::CNT_ADDR, rd);
        get(vts_pkg::CNT_ADDR, r2);
        cmp_w(r2, rd);
        ctl(32'h0000_0005, 4'h1);
        get(vts_pkg::CNT_ADDR, rd);
        cmp_w(rd, 32'h0);
        $display("test run done");
        frame_rst <= 1'b1;
        line_rst <= 1'b1;
        ctl(32'h0000_0024, 4'h1);
        get(vts_pkg::CNT_ADDR, rd);
        cmp_w(rd, 32'h0);
        ctl(32'h0000_0004, 4'h1);
        get(vts_pkg::CNT_ADDR, rd);
        cmp_w(32'(rd[27:16] != 12'h0), 32'h1);
        frame_rst <= 1'b0;
        ctl(32'h0000_0024, 4'h1);
        get(vts_pkg::CNT_ADDR, rd);
        cmp_w({20'h0, rd[27:16]}, 32'h0);
        cmp_w(32'(rd[11:0] != 12'h0), 32'h1);
        line_rst <= 1'b0;
        ctl(32'h0000_0506, 4'h3);
        $display("test slave done");
        axi_rd(8'h40, rd);
        cmp_r(resp, vts_pkg::RESP_ERR);
        cmp_w(rd, 32'h0);
        axi_wr(8'h40, 32'h1, 4'hf);
        cmp_r(resp, vts_pkg::RESP_ERR);
        get(8'h50, rd);
        cmp_w(rd, 32'h0);
        axi_wr(vts_pkg::HA_BUSRST, 32'h1, 4'hf);
        cmp_r(resp, vts_pkg::RESP_OK);
        axi_rd(vts_pkg::HA_STATUS, rd);
        cmp_w({31'h0, rd[1]}, 32'h1);
        axi_wr(vts_pkg::HA_BUSRST, 32'h0, 4'hf);
        get(vts_pkg::CNT_ADDR, rd);
        cmp_w(rd, 32'h0);
        $display("test bus reset done");
        end_sim();
    end
endmodule
`default_nettype wire

// ==== sim/vts_ipb_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module vts_ipb_checker (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // internal bus
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] be,
    input wire logic bus_rst,
    input wire logic ack,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////////////////////////////////////////////
    property p_ack_pulse; ack |=> !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_ack_cause; ack |-> req && $past(req); endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    // bus reset may cut a wait short
    property p_ack_soon; req && !ack && !bus_rst |-> ##[1:3] (ack || bus_rst); endproperty
    a_ack_soon: assert property (p_ack_soon)
        else $error("ack late");
    property p_req_held; req && !ack |=> req && $stable(addr) && $stable(we); endproperty
    a_req_held: assert property (p_req_held)
        else $error("request dropped before ack");
    property p_busrst_quiet; bus_rst |=> !ack; endproperty
    a_busrst_quiet: assert property (p_busrst_quiet)
        else $error("ack during bus reset");
    property p_ptr_top;
        ack && !we && addr == vts_pkg::CTRL_ADDR |-> rdata[15:14] == 2'h0;
    endproperty
    a_ptr_top: assert property (p_ptr_top)
        else $error("pointer top bits set");
    property p_cnt_pad;
        ack && !we && addr == vts_pkg::CNT_ADDR |-> rdata[31:28] == 4'h0 && rdata[15:12] == 4'h0;
    endproperty
    a_cnt_pad: assert property (p_cnt_pad)
        else $error("counter pad bits set");
    property p_unmapped;
        ack && !we && addr > vts_pkg::RAM_TOP && addr != vts_pkg::CTRL_ADDR
            && addr != vts_pkg::CNT_ADDR |-> rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_rdata_keep; !req && !bus_rst |=> $stable(rdata); endproperty
    a_rdata_keep: assert property (p_rdata_keep)
        else $error("read data changed while idle");
endmodule
`default_nettype wire
